// File: src/gpc_pin_ctrl.sv
// Eight-pin general purpose I/O controller with level interrupts
// Notes on behaviour
// - Eight pins, each input, push-pull or open-drain, each can interrupt.
// - Reset clears all direction bits; every pin is an input.
// - Reset clears all interrupt enable bits.
// - Reset clears polarity bits; interrupts trigger on low level.
// - Driver type bit selects push-pull or open-drain for outputs.
// - Open-drain drives low for value 0, releases for value 1.
// - Push-pull drives the pin to its value bit.
// - Reading value of an input pin returns the sampled pin state.
// - Input buffer off while output; pull-up normally on.
// - Lower six pins may be LEDs; reset mode taken from straps.
// - Each pin has readable interrupt status and its own enable.
// - Enabled statuses combine into one global pin event request.
// - A level counts only if active longer than 40 ns.
// - Polarity set: high level sets the status bit.
// - Polarity clear: low level sets the status bit.
// - LED-selected pin is an LED output; input buffer, pull-up off.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module gpc_pin_ctrl
  import gpc_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter int NUM_LEDS = 6
) (
  input  wire logic                CLK_SYS,
  input  wire logic                RST,
  input  wire logic [7:0]          ADDR,
  input  wire logic [31:0]         WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic      [31:0]         RDATA,
  input  wire logic [NUM_PINS-1:0] PIN_IN,
  output logic      [NUM_PINS-1:0] PIN_OUT,
  output logic      [NUM_PINS-1:0] PIN_OE,
  output logic      [NUM_PINS-1:0] PIN_IBUF_EN,
  output logic      [NUM_PINS-1:0] PIN_PULLUP_EN,
  input  wire logic [NUM_LEDS-1:0] LED_SELECT_STRAPS,
  input  wire logic [NUM_LEDS-1:0] LED_DRIVE,
  output logic                     PIN_IRQ
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (NUM_PINS != 8) begin : g_bad_pins
    $error("NUM_PINS must be 8 to fit the register layout");
  end
  if (NUM_LEDS < 1 || NUM_LEDS > NUM_PINS) begin : g_bad_leds
    $error("NUM_LEDS must lie between 1 and NUM_PINS");
  end

  localparam int CW = $clog2(GPC_MIN_LEVEL_CYC + 1);
  localparam logic [CW-1:0] LVL_DONE = CW'(GPC_MIN_LEVEL_CYC);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_direction_bits;
  logic [NUM_PINS-1:0] pin_value_bits;
  logic [NUM_PINS-1:0] pin_driver_type_bits;
  logic [NUM_PINS-1:0] pin_irq_polarity_bits;
  logic [NUM_PINS-1:0] pin_irq_enable;
  logic [NUM_PINS-1:0] pin_irq_status;
  logic [NUM_LEDS-1:0] led_select_bits;
  logic [NUM_PINS-1:0] sync_a;
  logic [NUM_PINS-1:0] sync_b;
  logic [NUM_PINS-1:0] level_hit;
  logic [NUM_PINS-1:0] led_mask;
  logic                strap_taken;
  logic                wr_data;
  logic                wr_cfg;
  logic                wr_int;
  logic                wr_led;

  assign wr_data = WR && (ADDR == GPC_DATA_DIR_OFS);
  assign wr_cfg  = WR && (ADDR == GPC_CFG_OFS);
  assign wr_int  = WR && (ADDR == GPC_INT_OFS);
  assign wr_led  = WR && (ADDR == GPC_LED_OFS) && strap_taken;
  assign led_mask = NUM_PINS'(led_select_bits);

  // ----------------------------------------------------------------------
  // Input synchronizer
  // ----------------------------------------------------------------------
  // Two flops per pin; only the second stage is read
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sync_a <= '1; // Pulled-up idle level, no false low after reset
      sync_b <= '1;
    end else begin
      sync_a <= PIN_IN;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Direction, value, driver type and polarity
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_direction_bits    <= GPC_DIR_RST;
      pin_value_bits        <= GPC_VAL_RST;
      pin_driver_type_bits  <= GPC_DRV_RST;
      pin_irq_polarity_bits <= GPC_POL_RST;
    end else begin
      if (wr_data) begin
        pin_direction_bits <= WDATA[GPC_DIR_POS +: NUM_PINS];
        pin_value_bits     <= WDATA[GPC_VAL_POS +: NUM_PINS];
      end
      if (wr_cfg) begin
        pin_driver_type_bits  <= WDATA[GPC_DRV_POS +: NUM_PINS];
        pin_irq_polarity_bits <= WDATA[GPC_POL_POS +: NUM_PINS];
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_irq_enable <= GPC_EN_RST;
    end else if (wr_int) begin
      pin_irq_enable <= WDATA[GPC_EN_POS +: NUM_PINS];
    end
  end

  // LED select: straps caught on the first clock after reset release
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      led_select_bits <= '0;
      strap_taken     <= 1'b0;
    end else if (!strap_taken) begin
      led_select_bits <= LED_SELECT_STRAPS;
      strap_taken     <= 1'b1;
    end else if (wr_led) begin
      led_select_bits <= WDATA[NUM_LEDS-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Per-pin level qualification and sticky status
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    logic [CW-1:0] lvl_cnt;
    logic          active;
    // Polarity picks which level is active
    assign active = pin_irq_polarity_bits[i] ~^ sync_b[i];
    // Count cycles the level has been active
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        lvl_cnt <= '0;
      end else if (!active) begin
        lvl_cnt <= '0;
      end else if (lvl_cnt != LVL_DONE) begin
        lvl_cnt <= lvl_cnt + CW'(1);
      end
    end
    assign level_hit[i] = (lvl_cnt == LVL_DONE);
    // Sticky status; a new hit wins over a write-one clear
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        pin_irq_status[i] <= GPC_STS_RST[i];
      end else if (level_hit[i]) begin
        pin_irq_status[i] <= 1'b1;
      end else if (wr_int && WDATA[GPC_STS_POS + i]) begin
        pin_irq_status[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  // Output level and enable; LED pins follow the LED source
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PIN_OUT       <= '0;
      PIN_OE        <= '0;
      PIN_IBUF_EN   <= '1;
      PIN_PULLUP_EN <= '1;
    end else begin
      for (int k = 0; k < NUM_PINS; k++) begin
        if (led_mask[k]) begin
          PIN_OUT[k]       <= LED_DRIVE[k % NUM_LEDS];
          PIN_OE[k]        <= 1'b1;
          PIN_IBUF_EN[k]   <= 1'b0;
          PIN_PULLUP_EN[k] <= 1'b0;
        end else begin
          PIN_PULLUP_EN[k] <= 1'b1;
          PIN_IBUF_EN[k]   <= !pin_direction_bits[k];
          if (!pin_direction_bits[k]) begin
            PIN_OUT[k] <= 1'b0;
            PIN_OE[k]  <= 1'b0;
          end else if (pin_driver_type_bits[k]) begin
            PIN_OUT[k] <= pin_value_bits[k];
            PIN_OE[k]  <= 1'b1;
          end else begin
            PIN_OUT[k] <= 1'b0;
            PIN_OE[k]  <= !pin_value_bits[k];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Combined interrupt request
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PIN_IRQ <= 1'b0;
    end else begin
      PIN_IRQ <= |(pin_irq_status & pin_irq_enable);
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Input pins read the synchronized level, outputs the value bit
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RDATA <= '0;
    end else begin
      RDATA <= '0;
      if (RD) begin
        unique case (ADDR)
          GPC_DATA_DIR_OFS: begin
            RDATA[GPC_DIR_POS +: NUM_PINS] <= pin_direction_bits;
            RDATA[GPC_VAL_POS +: NUM_PINS] <=
              (pin_direction_bits & pin_value_bits) |
              (~pin_direction_bits & sync_b);
          end
          GPC_CFG_OFS: begin
            RDATA[GPC_DRV_POS +: NUM_PINS] <= pin_driver_type_bits;
            RDATA[GPC_POL_POS +: NUM_PINS] <= pin_irq_polarity_bits;
          end
          GPC_INT_OFS: begin
            RDATA[GPC_STS_POS +: NUM_PINS] <= pin_irq_status;
            RDATA[GPC_EN_POS +: NUM_PINS]  <= pin_irq_enable;
          end
          GPC_LED_OFS: begin
            RDATA[NUM_LEDS-1:0] <= led_select_bits;
          end
          GPC_GLOBAL_OFS: begin
            RDATA[GPC_GEVT_POS] <= |(pin_irq_status&pin_irq_enable);
          end
          default: begin
            RDATA <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_irq_follows;
    @(posedge CLK_SYS) disable iff (RST)
      ##1 PIN_IRQ == $past(|(pin_irq_status & pin_irq_enable));
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("Combined request does not follow enabled status");

  property p_sticky;
    @(posedge CLK_SYS) disable iff (RST)
      (pin_irq_status[0] && !(wr_int && WDATA[GPC_STS_POS])) |=>
        pin_irq_status[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Status bit dropped without a write-one clear");

  property p_clear;
    @(posedge CLK_SYS) disable iff (RST)
      (wr_int && WDATA[GPC_STS_POS] && !level_hit[0]) |=>
        !pin_irq_status[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("Write-one did not clear status");

  property p_short_pulse;
    @(posedge CLK_SYS) disable iff (RST)
      !g_pin[0].active ##1 g_pin[0].active [*5] ##1 !g_pin[0].active
        |-> !level_hit[0];
  endproperty
  a_short_pulse: assert property (p_short_pulse)
    else $error("Short level was taken as an interrupt");

  property p_long_level;
    @(posedge CLK_SYS) disable iff (RST)
      g_pin[0].active [*6] |=> level_hit[0] ##1 pin_irq_status[0];
  endproperty
  a_long_level: assert property (p_long_level)
    else $error("Long active level did not set status");

  property p_open_drain;
    @(posedge CLK_SYS) disable iff (RST)
      (!led_mask[7] && pin_direction_bits[7] && !pin_driver_type_bits[7])
        |=> (PIN_OE[7] == !$past(pin_value_bits[7])) && !PIN_OUT[7];
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("Open-drain drive wrong");

  property p_push_pull;
    @(posedge CLK_SYS) disable iff (RST)
      (!led_mask[7] && pin_direction_bits[7] && pin_driver_type_bits[7])
        |=> PIN_OE[7] && (PIN_OUT[7] == $past(pin_value_bits[7]));
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("Push-pull drive wrong");

  property p_input_float;
    @(posedge CLK_SYS) disable iff (RST)
      (!led_mask[7] && !pin_direction_bits[7]) |=>
        !PIN_OE[7] && PIN_IBUF_EN[7] && PIN_PULLUP_EN[7];
  endproperty
  a_input_float: assert property (p_input_float)
    else $error("Input pin driven or buffer off");

  property p_led_pin;
    @(posedge CLK_SYS) disable iff (RST)
      led_mask[0] |=> !PIN_IBUF_EN[0] && !PIN_PULLUP_EN[0];
  endproperty
  a_led_pin: assert property (p_led_pin)
    else $error("LED pin kept input buffer or pull-up");

  c_irq: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(PIN_IRQ));
  c_clear: cover property (@(posedge CLK_SYS) disable iff (RST)
    $fell(pin_irq_status[0]));
  c_od: cover property (@(posedge CLK_SYS) disable iff (RST)
    pin_direction_bits[7] && !pin_driver_type_bits[7] && !PIN_OE[7]);

endmodule

// File: src/gpc_pkg.sv
// Package with register map and constants of the pin controller
package gpc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] GPC_DATA_DIR_OFS = 8'h00;
  localparam logic [7:0] GPC_CFG_OFS      = 8'h04;
  localparam logic [7:0] GPC_INT_OFS      = 8'h08;
  localparam logic [7:0] GPC_LED_OFS      = 8'h0C;
  localparam logic [7:0] GPC_GLOBAL_OFS   = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int GPC_DIR_POS   = 8;   // direction bits in data/dir word
  localparam int GPC_VAL_POS   = 0;   // value bits in data/dir word
  localparam int GPC_DRV_POS   = 0;   // driver type bits in config word
  localparam int GPC_POL_POS   = 8;   // polarity bits in config word
  localparam int GPC_STS_POS   = 0;   // status bits in interrupt word
  localparam int GPC_EN_POS    = 8;   // enable bits in interrupt word
  localparam int GPC_GEVT_POS  = 0;   // pin event bit in global status

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] GPC_DIR_RST = 8'h00;
  localparam logic [7:0] GPC_VAL_RST = 8'h00;
  localparam logic [7:0] GPC_DRV_RST = 8'h00;
  localparam logic [7:0] GPC_POL_RST = 8'h00;
  localparam logic [7:0] GPC_EN_RST  = 8'h00;
  localparam logic [7:0] GPC_STS_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int GPC_CLK_PERIOD_NS = 8;
  localparam int GPC_MIN_LEVEL_NS  = 40;
  // Level must last more than 40 ns: strictly greater, round up
  localparam int GPC_MIN_LEVEL_CYC =
    (GPC_MIN_LEVEL_NS / GPC_CLK_PERIOD_NS) + 1;

endpackage

// File: testbench/gpc_pin_model.sv
// Model of the external circuitry wired to the eight pins
`timescale 1ns/1ns
module gpc_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  logic [7:0] last = 8'h00;

  // Resolve each pin from device driver, outside driver and pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = ~last[i];  // Floating pin never holds a stale level
    end
  end

  // Remember the level so a floating pin keeps changing
  always_ff @(posedge clk) begin
    last <= pin_in;
  end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the eight-pin controller
`timescale 1ns/1ns
module testbench import gpc_pkg::*;;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clk_sys, rst, wr, rd, pin_irq;
  logic [7:0]  addr, pin_in, pin_out, pin_oe, pin_ibuf_en, pin_pullup_en;
  logic [7:0]  ext_en, ext_val;
  logic [31:0] wdata, rdata, rv;
  logic [5:0]  straps, led_drive;
  int          errors, tests_run;

  typedef struct {
    logic [7:0] dir, val, drv, oe, out, ibuf;
  } gpc_row_t;
  gpc_row_t rows [4] = '{
    '{8'hFF, 8'hA5, 8'hFF, 8'hFF, 8'hA5, 8'h00},
    '{8'hFF, 8'hA5, 8'h00, 8'h5A, 8'h00, 8'h00},
    '{8'h0F, 8'h33, 8'h05, 8'h0D, 8'h01, 8'hF0},
    '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF}};

  gpc_pin_ctrl u_dut (
    .CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .PIN_IBUF_EN(pin_ibuf_en),
    .PIN_PULLUP_EN(pin_pullup_en), .LED_SELECT_STRAPS(straps),
    .LED_DRIVE(led_drive), .PIN_IRQ(pin_irq));

  gpc_pin_model u_pins (
    .clk(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    rd <= 1'b1; addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d, exp, $sformatf("read %h", a));
  endtask

  task automatic drive_ext(input logic [7:0] en, val);
    @(posedge clk_sys);
    ext_en <= en; ext_val <= val;
  endtask

  task automatic wrap_up;
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Clock of 8 ns
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Watchdog cuts a hung run short
  initial begin
    #(8 * 20000);
    errors = errors + 1;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
    straps = 6'h21; led_drive = 6'h01; ext_en = 8'h00; ext_val = 8'h00;
    errors = 0; tests_run = 0;
    repeat (12) @(posedge clk_sys);
    chk({pin_oe, pin_ibuf_en, pin_pullup_en, 7'h0, pin_irq},
        32'h00FFFF00, "reset pins");
    rst <= 1'b0;
    rd_chk(GPC_LED_OFS, 32'h21);
    chk({pin_oe & 8'h21, pin_out & 8'h21, pin_ibuf_en & 8'h21,
         pin_pullup_en & 8'h21}, 32'h21010000, "led pins");
    wr_reg(GPC_LED_OFS, 32'h0);
    rd_chk(GPC_CFG_OFS, 32'h0);
    rd_reg(GPC_INT_OFS, rv);
    chk(rv & 32'hFF00, 32'h0, "enables");
    wr_reg(GPC_INT_OFS, 32'hFF);
    rd_chk(GPC_INT_OFS, 32'h0);
    // Table of output settings
    foreach (rows[i]) begin
      wr_reg(GPC_DATA_DIR_OFS, {16'h0, rows[i].dir, 8'h00});
      wr_reg(GPC_CFG_OFS, {24'h0, rows[i].drv});
      wr_reg(GPC_DATA_DIR_OFS, {16'h0, rows[i].dir, rows[i].val});
      repeat (3) @(posedge clk_sys);
      #1 chk({pin_oe, pin_out & pin_oe, pin_ibuf_en, pin_pullup_en},
             {rows[i].oe, rows[i].out, rows[i].ibuf, 8'hFF},
             "drive");
      rd_chk(GPC_DATA_DIR_OFS, {16'h0, rows[i].dir,
             (rows[i].val & rows[i].dir) | ~rows[i].dir});
    end
    // Inputs read the outside level
    wr_reg(GPC_DATA_DIR_OFS, 32'h0);
    drive_ext(8'hFF, 8'h3C);
    repeat (4) @(posedge clk_sys);
    rd_chk(GPC_DATA_DIR_OFS, 32'h3C);
    drive_ext(8'h00, 8'h00);
    // Low level interrupt, short pulse refused
    wr_reg(GPC_CFG_OFS, 32'h0);
    repeat (4) @(posedge clk_sys);
    wr_reg(GPC_INT_OFS, 32'hFF);
    wr_reg(GPC_INT_OFS, 32'h100);
    drive_ext(8'h01, 8'h00);
    repeat (4) @(posedge clk_sys);
    drive_ext(8'h00, 8'h00);
    repeat (10) @(posedge clk_sys);
    #1 chk({31'h0, pin_irq}, 32'h0, "short pulse");
    rd_chk(GPC_INT_OFS, 32'h100);
    drive_ext(8'h01, 8'h00);
    repeat (9) @(posedge clk_sys);
    drive_ext(8'h00, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1 chk({31'h0, pin_irq}, 32'h1, "irq low");
    rd_chk(GPC_INT_OFS, 32'h101);
    rd_chk(GPC_GLOBAL_OFS, 32'h1);
    wr_reg(GPC_INT_OFS, 32'h101);
    rd_chk(GPC_INT_OFS, 32'h100);
    #1 chk({31'h0, pin_irq}, 32'h0, "irq cleared");
    // High level polarity, enable gating, set wins over clear
    wr_reg(GPC_CFG_OFS, 32'h800);
    repeat (12) @(posedge clk_sys);
    rd_chk(GPC_INT_OFS, 32'h108);
    #1 chk({31'h0, pin_irq}, 32'h0, "masked");
    wr_reg(GPC_INT_OFS, 32'h808);
    rd_chk(GPC_INT_OFS, 32'h808);
    #1 chk({31'h0, pin_irq}, 32'h1, "irq high");
    // Unmapped address
    wr_reg(8'h14, 32'hFFFFFFFF);
    rd_chk(8'h14, 32'h0);
    // Reset in mid-run
    wr_reg(GPC_DATA_DIR_OFS, 32'hFF00);
    @(posedge clk_sys);
    rst <= 1'b1; straps <= 6'h00;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(GPC_DATA_DIR_OFS, 32'hFF);
    rd_chk(GPC_CFG_OFS, 32'h0);
    rd_reg(GPC_INT_OFS, rv);
    chk(rv & 32'hFF00, 32'h0, "enables again");
    #1 chk({31'h0, pin_irq}, 32'h0, "irq after reset");
    wrap_up();
  end
endmodule
